// [logic/rcsw_top.sv]
// Purpose: reset-cause flags, sleep entry, port freeze and wake-up
// Assumes: all inputs synchronous to clk; wdt_tick from watchdog osc
// Notes: clk is the always-on clock; osc_en_q gates the core clock
//
// Operation
// - awake watchdog reset clears pin-wake and time-out
// - watchdog wake from sleep clears all flags
// - pin-change wake sets pin-wake, time-out one
// - reset pin wake: time-out one, others zero
// - power-up sets time-out and power-down, clears pin-wake
// - awake reset pin clears pin-wake only
// - flags hold until a reset or sleep entry occurs
// - sleep entered only by sleep command
// - sleep clears watchdog, sets flags, stops oscillator
// - pins keep their state during sleep
// - watchdog reset never drives reset pin low
// - watchdog wakes only when enabled
// - pin change wakes only when enabled
// - every wake gives a full reset
// - compare pins against last port operation snapshot
// - watchdog cleared on every wake
// - hold reset while reset-delay timer counts
// - watchdog time-out in run or sleep restarts reset-delay timer
`timescale 1ns/100ps
module rcsw_top #(
  parameter int PORT_W = 6,
  parameter int WDT_W = 8,
  parameter logic [WDT_W-1:0] WDT_LIMIT = '1,
  parameter logic [19:0] DRT_POR_CYC = 20'(rcsw_pkg::DRT_POR_CYC),
  parameter logic [19:0] DRT_RC_CYC = 20'(rcsw_pkg::DRT_RC_CYC)
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // configuration straps
  input wire logic wdt_en,
  input wire logic ext_reset_en,
  input wire logic rc_osc_sel,
  // core commands
  input wire logic sleep_cmd,
  input wire logic clrwdt_cmd,
  input wire logic port_op,
  input wire logic [PORT_W-1:0] port_out,
  input wire logic [PORT_W-1:0] port_oe_n,
  // watchdog oscillator tick
  input wire logic wdt_tick,
  // pins
  input wire logic ext_reset_pin_n_i,
  output logic ext_reset_pin_n_o,
  output logic ext_reset_pin_n_oe_n,
  input wire logic [3:0] wake_pins,
  output logic [PORT_W-1:0] pin_out_q,
  output logic [PORT_W-1:0] pin_oe_n_q,
  // core control
  output logic core_reset_n_q,
  output logic osc_en_q,
  output logic sleeping_q,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q,
  output logic irq_q
);
  rcsw_pkg::rcsw_state_t state_q, state_d;
  logic timeout_flag_n_q, powerdown_flag_n_q, pin_wake_flag_q;
  logic first_q, por_q, wdt_fire, wdt_to, wdt_clear;
  logic ext_rst, pin_chg, wake, dly_start, dly_busy;
  logic [19:0] dly_len;
  logic [3:0] snap_q;
  logic [7:0] ctrl_q;
  logic [4:0] irq_stat_q, irq_mask_q, irq_ev;
  logic [WDT_W-1:0] wdt_count;
  logic woc_en;

  // ==========================================================
  // wake and reset events
  assign woc_en = ctrl_q[rcsw_pkg::CTL_WOC];
  assign ext_rst = ext_reset_en && !ext_reset_pin_n_i;
  assign wdt_fire = wdt_to && wdt_en;
  assign pin_chg = woc_en && (wake_pins != snap_q);
  assign wake = ext_rst || wdt_fire || pin_chg;

  // ==========================================================
  // next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      rcsw_pkg::ST_HOLD:
        if (!dly_busy && !dly_start)
          state_d = rcsw_pkg::ST_RUN;
      rcsw_pkg::ST_RUN:
        if (ext_rst || wdt_fire)
          state_d = rcsw_pkg::ST_HOLD;
        else if (sleep_cmd)
          state_d = rcsw_pkg::ST_SLEEP;
      rcsw_pkg::ST_SLEEP:
        if (wake)
          state_d = rcsw_pkg::ST_HOLD;
      default:
        state_d = rcsw_pkg::ST_HOLD;
    endcase
  end

  // state register; first_q marks the cycle after power-on reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q <= rcsw_pkg::ST_HOLD;
      first_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      first_q <= 1'b0;
    end
  end

  // power-up delay applies until the first release
  always_ff @(posedge clk)
  begin
    if (!nrst)
      por_q <= 1'b1;
    else if (state_q == rcsw_pkg::ST_HOLD && state_d == rcsw_pkg::ST_RUN)
      por_q <= 1'b0;
  end

  // ==========================================================
  // reset-delay timer
  // restart on every reset entry; pin low keeps reloading
  assign dly_start = first_q ||
                     (state_q != rcsw_pkg::ST_HOLD &&
                      state_d == rcsw_pkg::ST_HOLD) ||
                     (state_q == rcsw_pkg::ST_HOLD && ext_rst);
  // short delay only after the first release and with rc oscillator
  assign dly_len = (!por_q && rc_osc_sel) ? DRT_RC_CYC : DRT_POR_CYC;

  rcsw_dly #(.W(rcsw_pkg::DRT_W)) u_dly (
    .clk(clk),
    .nrst(nrst),
    .start(dly_start),
    .len(dly_len),
    .busy(dly_busy)
  );

  // ==========================================================
  // watchdog; runs on the tick so it works with the core clock off
  // clear on sleep entry and on every wake
  assign wdt_clear = clrwdt_cmd ||
                     (state_q == rcsw_pkg::ST_RUN && sleep_cmd) ||
                     (state_q == rcsw_pkg::ST_SLEEP && wake);

  rcsw_wdt #(.W(WDT_W), .LIMIT(WDT_LIMIT)) u_wdt (
    .clk(clk),
    .nrst(nrst),
    .en(wdt_en),
    .tick(wdt_tick),
    .clear(wdt_clear),
    .count_q(wdt_count),
    .fire_q(wdt_to)
  );

  // ==========================================================
  // reset-cause flags; only reset events and sleep entry touch them
  // held between resets and sleep entries
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      timeout_flag_n_q <= 1'b1;
      powerdown_flag_n_q <= 1'b1;
      pin_wake_flag_q <= 1'b0;
    end
    else if (state_q == rcsw_pkg::ST_RUN)
    begin
      if (ext_rst)
        pin_wake_flag_q <= 1'b0;
      else if (wdt_fire)
      begin
        pin_wake_flag_q <= 1'b0;
        timeout_flag_n_q <= 1'b0;
      end
      else if (sleep_cmd)
      begin
        timeout_flag_n_q <= 1'b1;
        powerdown_flag_n_q <= 1'b0;
      end
    end
    else if (state_q == rcsw_pkg::ST_SLEEP && wake)
    begin
      powerdown_flag_n_q <= 1'b0;
      pin_wake_flag_q <= !ext_rst && !wdt_fire;
      timeout_flag_n_q <= ext_rst || !wdt_fire;
    end
  end

  // ==========================================================
  // pin snapshot at each port operation while running
  always_ff @(posedge clk)
  begin
    if (!nrst)
      snap_q <= 4'h0;
    else if (port_op && state_q == rcsw_pkg::ST_RUN)
      snap_q <= wake_pins;
  end

  // ==========================================================
  // core control outputs, taken from the next state
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      core_reset_n_q <= 1'b0;
      osc_en_q <= 1'b1;
      sleeping_q <= 1'b0;
    end
    else
    begin
      // core held in reset during hold
      core_reset_n_q <= (state_d != rcsw_pkg::ST_HOLD);
      // driver off in sleep, back on before release
      osc_en_q <= (state_d != rcsw_pkg::ST_SLEEP);
      sleeping_q <= (state_d == rcsw_pkg::ST_SLEEP);
    end
  end

  // ==========================================================
  // port pins; hi-z in reset, frozen while asleep
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end
    else if (state_d == rcsw_pkg::ST_HOLD)
    begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end
    // hold last driven state in sleep
    else if (state_d != rcsw_pkg::ST_SLEEP)
    begin
      pin_out_q <= port_out;
      pin_oe_n_q <= port_oe_n;
    end
  end

  // reset pin is input only: a watchdog reset must not pull it low
  always_ff @(posedge clk)
  begin
    ext_reset_pin_n_o <= 1'b1;
    ext_reset_pin_n_oe_n <= 1'b1;
  end

  // ==========================================================
  // register writes: control and mask
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_q <= rcsw_pkg::CTRL_RST;
      irq_mask_q <= rcsw_pkg::IRQ_RST;
    end
    else if (wr && addr == rcsw_pkg::ADDR_CTRL)
      ctrl_q <= wdata;
    else if (wr && addr == rcsw_pkg::ADDR_IRQ_MASK)
      irq_mask_q <= wdata[4:0];
  end

  // sticky events; a set in the clearing cycle wins
  always_comb
  begin
    irq_ev = '0;
    irq_ev[rcsw_pkg::IRQ_WDT] = wdt_fire;
    irq_ev[rcsw_pkg::IRQ_PIN] = state_q == rcsw_pkg::ST_SLEEP && pin_chg;
    irq_ev[rcsw_pkg::IRQ_EXT] = ext_rst && state_q != rcsw_pkg::ST_HOLD;
    irq_ev[rcsw_pkg::IRQ_SLEEP] = state_q == rcsw_pkg::ST_RUN &&
                                  state_d == rcsw_pkg::ST_SLEEP;
    irq_ev[rcsw_pkg::IRQ_REL] = state_q == rcsw_pkg::ST_HOLD &&
                                state_d == rcsw_pkg::ST_RUN;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq_stat_q <= rcsw_pkg::IRQ_RST;
    else if (wr && addr == rcsw_pkg::ADDR_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~wdata[4:0]) | irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  // level interrupt, one cycle behind the status
  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_stat_q & irq_mask_q);
  end

  // ==========================================================
  // register reads; unmapped addresses read zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata_q <= 8'h00;
    else if (rd)
    begin
      rdata_q <= 8'h00;
      unique case (addr)
        rcsw_pkg::ADDR_FLAGS:
        begin
          rdata_q[rcsw_pkg::FLD_SLEEPING] <= state_q == rcsw_pkg::ST_SLEEP;
          rdata_q[rcsw_pkg::FLD_HOLDING] <= state_q == rcsw_pkg::ST_HOLD;
          rdata_q[rcsw_pkg::FLD_PD] <= powerdown_flag_n_q;
          rdata_q[rcsw_pkg::FLD_TO] <= timeout_flag_n_q;
          rdata_q[rcsw_pkg::FLD_PW] <= pin_wake_flag_q;
        end
        rcsw_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
        rcsw_pkg::ADDR_IRQ_STAT: rdata_q <= {3'h0, irq_stat_q};
        rcsw_pkg::ADDR_IRQ_MASK: rdata_q <= {3'h0, irq_mask_q};
        rcsw_pkg::ADDR_WDT: rdata_q <= 8'(wdt_count);
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_por_flags: assert property (
    first_q |-> timeout_flag_n_q && powerdown_flag_n_q && !pin_wake_flag_q)
    else $error("power-up flags wrong");
  a_wdt_awake: assert property (
    state_q == rcsw_pkg::ST_RUN && wdt_fire && !ext_rst |=>
    !timeout_flag_n_q && !pin_wake_flag_q &&
    powerdown_flag_n_q == $past(powerdown_flag_n_q))
    else $error("awake watchdog flags wrong");
  a_wdt_wake: assert property (
    state_q == rcsw_pkg::ST_SLEEP && wdt_fire && !ext_rst |=>
    !timeout_flag_n_q && !powerdown_flag_n_q && !pin_wake_flag_q)
    else $error("watchdog wake flags wrong");
  a_pin_wake: assert property (
    state_q == rcsw_pkg::ST_SLEEP && pin_chg && !ext_rst && !wdt_fire |=>
    pin_wake_flag_q && timeout_flag_n_q && !powerdown_flag_n_q)
    else $error("pin wake flags wrong");
  a_ext_wake: assert property (
    state_q == rcsw_pkg::ST_SLEEP && ext_rst |=>
    !pin_wake_flag_q && timeout_flag_n_q && !powerdown_flag_n_q)
    else $error("pin reset wake flags wrong");
  a_ext_awake: assert property (
    state_q == rcsw_pkg::ST_RUN && ext_rst |=> !pin_wake_flag_q &&
    $stable(timeout_flag_n_q) && $stable(powerdown_flag_n_q))
    else $error("awake pin reset flags wrong");
  a_flags_hold: assert property (
    state_q != rcsw_pkg::ST_SLEEP && !ext_rst && !wdt_fire && !sleep_cmd
    |=> $stable({timeout_flag_n_q, powerdown_flag_n_q, pin_wake_flag_q}))
    else $error("flags changed without reset");
  a_sleep_cmd: assert property (
    $rose(sleeping_q) |-> $past(sleep_cmd) &&
    $past(state_q) == rcsw_pkg::ST_RUN)
    else $error("sleep without command");
  a_sleep_entry: assert property (
    state_q == rcsw_pkg::ST_RUN && sleep_cmd && !ext_rst && !wdt_fire |=>
    timeout_flag_n_q && !powerdown_flag_n_q && !osc_en_q && wdt_count == '0)
    else $error("sleep entry effects wrong");
  a_pin_freeze: assert property (
    sleeping_q && $past(sleeping_q) |->
    $stable(pin_out_q) && $stable(pin_oe_n_q))
    else $error("pins moved in sleep");
  a_no_pin_drive: assert property (
    ext_reset_pin_n_oe_n)
    else $error("reset pin driven");
  a_wdt_gate: assert property (
    state_q == rcsw_pkg::ST_SLEEP && !wdt_en && !ext_rst && !pin_chg
    |=> state_q == rcsw_pkg::ST_SLEEP)
    else $error("disabled watchdog woke device");
  a_woc_gate: assert property (
    state_q == rcsw_pkg::ST_SLEEP && !woc_en && !ext_rst && !wdt_fire
    |=> state_q == rcsw_pkg::ST_SLEEP)
    else $error("disabled pin change woke device");
  a_wake_reset: assert property (
    state_q == rcsw_pkg::ST_SLEEP && wake |=> !core_reset_n_q ##1
    !core_reset_n_q)
    else $error("wake without reset");
  a_snap_take: assert property (
    port_op && state_q == rcsw_pkg::ST_RUN |=> snap_q == $past(wake_pins))
    else $error("snapshot not taken");
  a_wake_wdt_clr: assert property (
    state_q == rcsw_pkg::ST_SLEEP && wake |=> wdt_count == '0)
    else $error("watchdog not cleared on wake");
  a_hold_delay: assert property (
    state_q == rcsw_pkg::ST_HOLD && dly_busy |=> !core_reset_n_q)
    else $error("released during delay");
  a_wdt_restart: assert property (
    state_q == rcsw_pkg::ST_RUN && wdt_fire |=> dly_busy && !core_reset_n_q)
    else $error("watchdog did not restart delay");
  a_osc_first: assert property (
    $rose(core_reset_n_q) |-> osc_en_q && $past(osc_en_q))
    else $error("released with oscillator off");

  c_pin_wake: cover property (sleeping_q ##1 pin_wake_flag_q);
  c_wdt_wake: cover property (sleeping_q && wdt_fire);
  c_release: cover property ($rose(core_reset_n_q));
endmodule // rcsw_top

// [logic/rcsw_pkg.sv]
// Purpose: shared constants for the reset-cause and sleep/wake block
// Assumes: 40 MHz core clock, 8-bit register port
// Notes: times are kept in their own unit, cycle counts derive from them
package rcsw_pkg;
  // ==========================================================
  // clock and reset-delay timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int DRT_POR_US = 18000;
  localparam int DRT_RC_US = 300;
  // least times, so round up to whole cycles
  localparam int DRT_POR_CYC = (DRT_POR_US * 1000 + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int DRT_RC_CYC = (DRT_RC_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int DRT_W = 20;
  // ==========================================================
  // register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_FLAGS = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h2;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
  localparam logic [2:0] ADDR_WDT = 3'h4;
  // flags register fields
  localparam int FLD_SLEEPING = 0;
  localparam int FLD_HOLDING = 1;
  localparam int FLD_PD = 3;
  localparam int FLD_TO = 4;
  localparam int FLD_PW = 7;
  // control register fields and reset value
  localparam int CTL_WOC = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // interrupt status / mask fields
  localparam int IRQ_WDT = 0;
  localparam int IRQ_PIN = 1;
  localparam int IRQ_EXT = 2;
  localparam int IRQ_SLEEP = 3;
  localparam int IRQ_REL = 4;
  localparam int IRQ_W = 5;
  localparam logic [4:0] IRQ_RST = 5'h00;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10
  } rcsw_state_t;
endpackage

// [logic/rcsw_wdt.sv]
// Purpose: watchdog counter advanced by ticks of the watchdog oscillator
// Assumes: tick is a one-cycle pulse synchronous to clk
// Notes: clear wins over a tick in the same cycle
`timescale 1ns/100ps
module rcsw_wdt #(
  parameter int W = 8,
  parameter logic [W-1:0] LIMIT = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic en,
  input wire logic tick,
  input wire logic clear,
  // results
  output logic [W-1:0] count_q,
  output logic fire_q
);
  // ==========================================================
  // count ticks; wrap and fire at the limit
  always_ff @(posedge clk)
  begin
    if (!nrst || clear || !en)
    begin
      count_q <= '0;
      fire_q <= 1'b0;
    end
    else
    begin
      fire_q <= tick && (count_q == LIMIT);
      if (tick)
        count_q <= (count_q == LIMIT) ? '0 : count_q + 1'b1;
    end
  end
endmodule // rcsw_wdt

// [logic/rcsw_dly.sv]
// Purpose: reset-delay down counter
// Assumes: start may stay high and reload each cycle, len at least one
// Notes: busy rises the cycle after start
`timescale 1ns/100ps
module rcsw_dly #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic [W-1:0] len,
  // status
  output logic busy
);
  logic [W-1:0] cnt_q;

  // ==========================================================
  // reload on start, then count down to zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_q <= '0;
    else if (start)
      cnt_q <= len;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign busy = (cnt_q != '0);
endmodule // rcsw_dly

// [test/rcsw_far_model.sv]
// Purpose: far side of the block: watchdog osc, reset pin, wake pins
// Assumes: one clock; the bench commands every event
// Notes: reset pin has a pull-up, so a released pin reads high
`timescale 1ns/100ps
module rcsw_far_model (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic tick_on,
  input wire logic press,
  input wire logic [3:0] flip,
  // reset pin as driven by the design
  input wire logic pin_o,
  input wire logic pin_oe_n,
  // levels seen by the design
  output logic pin_level,
  output logic wdt_tick,
  output logic [3:0] wake_pins
);
  logic [1:0] div_q;
  // ==========================================================
  // watchdog oscillator
  // slow tick, one in four cycles, so a fire takes a while
  initial div_q = 2'h0;
  always_ff @(posedge clk)
  begin
    div_q <= tick_on ? div_q + 2'h1 : 2'h0;
  end
  assign wdt_tick = tick_on && (div_q == 2'h3);
  // ==========================================================
  // pins
  // open drain pin
  // pull-up wins unless the button or the design pulls low
  assign pin_level = !(press || (!pin_oe_n && !pin_o));
  // wake pins idle at a fixed pattern, flipped on command
  assign wake_pins = 4'h5 ^ flip;
endmodule // rcsw_far_model

// [test/reset_cause_sleep_wake_bench.sv]
// Purpose: self-checking bench for the reset-cause and sleep/wake block
// Assumes: short reset-delay counts (20, 8) and watchdog limit 3
// Notes: reset pin acts as reset and rc oscillator is selected until t_irq
`timescale 1ns/100ps
module reset_cause_sleep_wake_bench;
  logic clk, nrst, wdt_en, sleep_cmd, port_op, wr, rd;
  logic clrwdt_cmd, rc_sel;
  logic tick_on, press, wdt_tick, pin_level, pin_o, pin_oe_n;
  logic core_reset_n_q, osc_en_q, sleeping_q, irq_q;
  logic [5:0] port_out, port_oe_n, pin_out_q, pin_oe_n_q;
  logic [3:0] flip, wake_pins;
  logic [2:0] addr;
  logic [7:0] wdata, rdata_q;
  int miscompares = 0;
  int checks = 0;
  // ==========================================================
  // design and far side
  rcsw_top #(.WDT_LIMIT(8'h03), .DRT_POR_CYC(20'h00014),
    .DRT_RC_CYC(20'h00008)) rcsw_top_inst (.clk(clk), .nrst(nrst),
    .wdt_en(wdt_en), .ext_reset_en(1'b1), .rc_osc_sel(rc_sel),
    .sleep_cmd(sleep_cmd), .clrwdt_cmd(clrwdt_cmd), .port_op(port_op),
    .port_out(port_out), .port_oe_n(port_oe_n), .wdt_tick(wdt_tick),
    .ext_reset_pin_n_i(pin_level), .ext_reset_pin_n_o(pin_o),
    .ext_reset_pin_n_oe_n(pin_oe_n), .wake_pins(wake_pins),
    .pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q),
    .core_reset_n_q(core_reset_n_q), .osc_en_q(osc_en_q),
    .sleeping_q(sleeping_q), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .irq_q(irq_q));
  rcsw_far_model rcsw_far_model_inst (.clk(clk), .tick_on(tick_on),
    .press(press), .flip(flip), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .pin_level(pin_level), .wdt_tick(wdt_tick), .wake_pins(wake_pins));
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // shared tasks
  task stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobes, read data taken in the cycle after
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata_q;
  endtask
  // bounded wait; an expired wait ends the run
  task wait_core(input logic lvl, output int n);
    n = 0;
    while (core_reset_n_q !== lvl && n < 400)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 400)
    begin
      check({7'h0, core_reset_n_q}, {7'h0, lvl});
      stop_test;
    end
  endtask
  task do_sleep;
    @(posedge clk);
    port_op <= 1'b1;
    @(posedge clk);
    port_op <= 1'b0;
    sleep_cmd <= 1'b1;
    @(posedge clk);
    sleep_cmd <= 1'b0;
    #1;
  endtask
  // pin held low three cycles, then wait out the hold
  task press_pin(output int n);
    @(posedge clk);
    press <= 1'b1;
    repeat (3) @(posedge clk);
    press <= 1'b0;
    #1 check({7'h0, core_reset_n_q}, 8'h00);
    wait_core(1'b1, n);
  endtask
  // ==========================================================
  // scenarios
  task t_power;
    int n;
    logic [7:0] v;
    @(posedge clk);
    sleep_cmd <= 1'b1;
    @(posedge clk);
    sleep_cmd <= 1'b0;
    #1 check({7'h0, sleeping_q}, 8'h00);
    wait_core(1'b1, n);
    check(8'(n >= 18), 8'h01);
    rd_reg(rcsw_pkg::ADDR_FLAGS, v);
    check(v, 8'h18);
    rd_reg(3'h5, v);
    check(v, 8'h00);
    $display("t_power done");
  endtask
  task t_wdt_run;
    int n;
    logic [7:0] v;
    @(posedge clk);
    wdt_en <= 1'b1;
    tick_on <= 1'b1;
    // clearing every eight cycles keeps the count below the limit
    repeat (5)
    begin
      repeat (7) @(posedge clk);
      clrwdt_cmd <= 1'b1;
      @(posedge clk);
      clrwdt_cmd <= 1'b0;
    end
    #1 check({7'h0, core_reset_n_q}, 8'h01);
    wait_core(1'b0, n);
    @(posedge clk);
    tick_on <= 1'b0;
    wdt_en <= 1'b0;
    #1 check({6'h0, pin_o, pin_oe_n}, 8'h03);
    wait_core(1'b1, n);
    rd_reg(rcsw_pkg::ADDR_FLAGS, v);
    check(v, 8'h08);
    $display("t_wdt_run done");
  endtask
  task t_pin_wake;
    int n;
    logic [7:0] v;
    wr_reg(rcsw_pkg::ADDR_CTRL, 8'h01);
    port_out <= 6'h2a;
    port_oe_n <= 6'h30;
    do_sleep;
    check({6'h0, sleeping_q, osc_en_q}, 8'h02);
    rd_reg(rcsw_pkg::ADDR_FLAGS, v);
    check(v, 8'h11);
    @(posedge clk);
    port_out <= 6'h15;
    port_oe_n <= 6'h00;
    repeat (2) @(posedge clk);
    #1 check({2'h0, pin_out_q}, 8'h2a);
    check({2'h0, pin_oe_n_q}, 8'h30);
    @(posedge clk);
    flip <= 4'h8;
    wait_core(1'b0, n);
    check(8'(n <= 4), 8'h01);
    check({7'h0, osc_en_q}, 8'h01);
    wait_core(1'b1, n);
    rd_reg(rcsw_pkg::ADDR_FLAGS, v);
    check(v, 8'h90);
    press_pin(n);
    check(8'(n <= 12), 8'h01);
    rd_reg(rcsw_pkg::ADDR_FLAGS, v);
    check(v, 8'h10);
    $display("t_pin_wake done");
  endtask
  task t_ext_sleep;
    int n;
    logic [7:0] v;
    wr_reg(rcsw_pkg::ADDR_CTRL, 8'h00);
    do_sleep;
    @(posedge clk);
    flip <= 4'h0;
    tick_on <= 1'b1;
    repeat (20) @(posedge clk);
    tick_on <= 1'b0;
    #1 check({7'h0, sleeping_q}, 8'h01);
    press_pin(n);
    rd_reg(rcsw_pkg::ADDR_FLAGS, v);
    check(v, 8'h10);
    $display("t_ext_sleep done");
  endtask
  task t_wdt_sleep;
    int n;
    logic [7:0] v;
    do_sleep;
    @(posedge clk);
    wdt_en <= 1'b1;
    tick_on <= 1'b1;
    wait_core(1'b0, n);
    @(posedge clk);
    tick_on <= 1'b0;
    wdt_en <= 1'b0;
    wait_core(1'b1, n);
    check(8'(n >= 7), 8'h01);
    rd_reg(rcsw_pkg::ADDR_FLAGS, v);
    check(v, 8'h00);
    $display("t_wdt_sleep done");
  endtask
  task t_irq;
    int n;
    logic [7:0] v;
    wr_reg(rcsw_pkg::ADDR_IRQ_STAT, 8'h1f);
    wr_reg(rcsw_pkg::ADDR_IRQ_MASK, 8'h08);
    do_sleep;
    repeat (2) @(posedge clk);
    #1 check({7'h0, irq_q}, 8'h01);
    wr_reg(rcsw_pkg::ADDR_IRQ_STAT, 8'h08);
    repeat (2) @(posedge clk);
    #1 check({7'h0, irq_q}, 8'h00);
    rd_reg(rcsw_pkg::ADDR_IRQ_STAT, v);
    check({4'h0, v[3], 3'h0}, 8'h00);
    // without the rc oscillator a later reset waits the long delay
    @(posedge clk);
    rc_sel <= 1'b0;
    press_pin(n);
    check(8'(n >= 20), 8'h01);
    $display("t_irq done");
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    nrst = 1'b0;
    wdt_en = 1'b0;
    sleep_cmd = 1'b0;
    clrwdt_cmd = 1'b0;
    rc_sel = 1'b1;
    port_op = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    tick_on = 1'b0;
    press = 1'b0;
    flip = 4'h0;
    port_out = 6'h00;
    port_oe_n = 6'h3f;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_power;
    t_wdt_run;
    t_pin_wake;
    t_ext_sleep;
    t_wdt_sleep;
    t_irq;
    stop_test;
  end
endmodule // reset_cause_sleep_wake_bench
